//--- eirqt_pkg.sv
// Shared constants for the external interrupt inputs and interval timers.
// How it works
// - Twelve independent external interrupt inputs, numbered 0 to 11.
// - Each input triggers on a rising or falling edge, or a high or low level.
// - After reset every input detects the falling edge.
// - Any pulse longer than 1 us is caught, whatever its length.
// - A per-input sense bit inverts the default active sense.
// - Sense picks high or low for levels, rising or falling for edges.
// - An input interrupts the host only when armed and enabled.
// - Software can raise a request on any input; unlike a line trigger, it is not forwarded to the chain line.
// - Each input can forward its trigger onto the chain interrupt line.
// - Eight interval timers, numbered 0 to 7, each with a 32-bit count.
// - Each timer has a selectable tick period; interval is count times tick.
// - Timers are one-shot or periodic; periodic reloads the load value at zero.
// - Software starts, stops, loads, modifies and reads each timer and its mode.
// - A running timer reaching zero raises an event that can interrupt.
// - Timer expiry can interrupt the host, feed the chain, and drive an output line.
// - After reset all inputs and chain forwards are disarmed and disabled.
// - Armed inputs latch requests; disarming clears and ignores them.
// - A disabled armed input keeps requests and delivers once enabled.
// - The host clears pending; no new delivery while pending is set.
`default_nettype none

package eirqt_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_IN = 12;
	localparam int NUM_TMR = 8;
	localparam int CNT_W = 32;
	localparam int ADDR_W = 8;
	localparam int TIDX_W = 3;

	// ==========================================================
	// Tick generation: a 1 us base tick then decade dividers.
	localparam int CLK_MHZ = 200;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;
	localparam int US_W = $clog2(TICK_CYC);
	localparam int RES_STEPS = 4;
	localparam int RES_W = 2;
	localparam logic [3:0] DECADE_LAST = 4'h9;

	// ==========================================================
	// Register byte addresses.
	localparam logic [ADDR_W-1:0] A_ARM = 8'h00;
	localparam logic [ADDR_W-1:0] A_ENA = 8'h04;
	localparam logic [ADDR_W-1:0] A_MODE = 8'h08;
	localparam logic [ADDR_W-1:0] A_SENSE = 8'h0c;
	localparam logic [ADDR_W-1:0] A_CHAIN = 8'h10;
	localparam logic [ADDR_W-1:0] A_REQ = 8'h14;
	localparam logic [ADDR_W-1:0] A_PEND = 8'h18;
	localparam logic [ADDR_W-1:0] A_TPEND = 8'h1c;
	localparam logic [ADDR_W-1:0] A_TIE = 8'h20;
	localparam logic [ADDR_W-1:0] A_TCHAIN = 8'h24;
	localparam logic [ADDR_W-1:0] A_TOUT = 8'h28;
	localparam logic [ADDR_W-1:0] A_TBASE = 8'h40;
	localparam logic [ADDR_W-1:0] A_TEND = 8'hc0;
	localparam logic [1:0] T_CTRL = 2'h0;
	localparam logic [1:0] T_LOAD = 2'h1;
	localparam logic [1:0] T_COUNT = 2'h2;

	// ==========================================================
	// Timer control word fields.
	localparam int CTL_START = 0;
	localparam int CTL_STOP = 1;
	localparam int CTL_PER = 2;
	localparam int CTL_RES = 4;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

`default_nettype wire

//--- eirqt_timer.sv
// One down-counting interval timer with one-shot and periodic reload.
`default_nettype none

module eirqt_timer
	import eirqt_pkg::*;
#(
	parameter int W = CNT_W
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic tick_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic periodic_i,
	input wire logic load_we_i,
	input wire logic mod_we_i,
	input wire logic [W-1:0] wdata_i,
	output logic [W-1:0] count_o,
	output logic [W-1:0] load_o,
	output logic running_o,
	output logic expire_o
);
	logic [W-1:0] count_reg, count_next, load_reg, load_next;
	logic run_reg, run_next, exp_reg, exp_next;
	logic hit_zero;

	// ==========================================================
	// Counting. A tick at count one (or zero) is the expiry.
	assign hit_zero = run_reg && tick_i && (count_reg <= W'(1));

	always_comb begin
		count_next = count_reg;
		load_next = load_reg;
		run_next = run_reg;
		exp_next = hit_zero;
		if (run_reg && tick_i) begin
			if (hit_zero) begin
				if (periodic_i) begin
					count_next = load_reg;
				end else begin
					count_next = '0;
					run_next = 1'b0;
				end
			end else begin
				count_next = count_reg - W'(1);
			end
		end
		// Software writes win over the tick in the same cycle.
		if (load_we_i) begin
			load_next = wdata_i;
			count_next = wdata_i;
		end else if (mod_we_i) begin
			count_next = wdata_i;
		end
		if (stop_i) begin
			run_next = 1'b0;
		end else if (start_i) begin
			run_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			count_reg <= '0;
			load_reg <= '0;
			run_reg <= 1'b0;
			exp_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			load_reg <= load_next;
			run_reg <= run_next;
			exp_reg <= exp_next;
		end
	end

	assign count_o = count_reg;
	assign load_o = load_reg;
	assign running_o = run_reg;
	assign expire_o = exp_reg;

	// ==========================================================
	// Checks.
	a_count_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		run_reg && tick_i && count_reg > W'(1) && !load_we_i && !mod_we_i |=> count_reg == $past(count_reg) - W'(1))
		else $error("timer did not step down by one");
	a_oneshot_stop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		hit_zero && !periodic_i && !start_i |=> !run_reg ##0 expire_o)
		else $error("one-shot timer kept running after zero");
	a_periodic_reload: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		hit_zero && periodic_i && !load_we_i && !mod_we_i && !stop_i |=> count_reg == load_reg && run_reg)
		else $error("periodic timer did not reload");
endmodule // eirqt_timer

`default_nettype wire

//--- eirqt_top.sv
// External interrupt inputs and interval timers behind an AXI4-Lite slave.
`default_nettype none

module eirqt_top
	import eirqt_pkg::*;
#(
	parameter int NIN = NUM_IN,
	parameter int NTMR = NUM_TMR
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic [NIN-1:0] ext_irq_i,
	output logic [NIN-1:0] in_irq_o,
	output logic [NIN-1:0] in_chain_o,
	output logic [NTMR-1:0] tmr_irq_o,
	output logic [NTMR-1:0] tmr_chain_o,
	output logic [NTMR-1:0] tmr_out_o
);
	// ==========================================================
	// Declarations
	logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [ADDR_W-1:0] waddr_reg, waddr_next, woff, roff;
	logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next, rd_mux;
	logic [3:0] wstrb_reg, wstrb_next;
	logic wr_fire, wr_tmr, rd_tmr;
	logic [TIDX_W-1:0] widx, ridx;
	logic [NIN-1:0] arm_reg, arm_next, ena_reg, ena_next, mode_reg, mode_next;
	logic [NIN-1:0] sense_reg, sense_next, chain_reg, chain_next;
	logic [NIN-1:0] sync_a_reg, sync_b_reg, sync_c_reg, trig, swreq, pclr, deliver;
	logic [NIN-1:0] req_reg, req_next, pend_reg, pend_next, ichain_reg, ichain_next;
	logic [NTMR-1:0] tie_reg, tie_next, tch_reg, tch_next, tout_reg, tout_next;
	logic [NTMR-1:0] per_reg, per_next, trun, texp, tclr;
	logic [NTMR-1:0] tpend_reg, tpend_next, tirq_reg, tirq_next, tchain_reg, tchain_next, tline_reg, tline_next;
	logic [RES_W-1:0] res_reg [NTMR];
	logic [RES_W-1:0] res_next [NTMR];
	logic [CNT_W-1:0] tcount [NTMR];
	logic [CNT_W-1:0] tload [NTMR];
	logic [RES_STEPS-1:0] tick;
	logic [US_W-1:0] us_reg, us_next;

	// Byte-lane merge for read/write registers.
	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
		for (int b = 0; b < 4; b++) begin
			if (s[b]) begin
				o[8*b +: 8] = n[8*b +: 8];
			end
		end
		return o;
	endfunction

	// Decodes whether a byte address names a register.
	function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = a - A_TBASE;
		return (a[1:0] == 2'h0) && ((a <= A_TOUT) || (a >= A_TBASE && a < A_TEND && off[3:2] != 2'h3));
	endfunction

	// ==========================================================
	// AXI4-Lite write channel: address and data are latched independently.
	assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
	assign woff = waddr_reg - A_TBASE;
	assign widx = woff[TIDX_W+3:4];
	assign wr_tmr = waddr_reg >= A_TBASE && waddr_reg < A_TEND;

	always_comb begin
		aw_full_next = aw_full_reg;
		w_full_next = w_full_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		if (s_axi_awvalid_i && awready_reg) begin
			aw_full_next = 1'b1;
			waddr_next = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready_reg) begin
			w_full_next = 1'b1;
			wdata_next = s_axi_wdata_i;
			wstrb_next = s_axi_wstrb_i;
		end
		if (bvalid_reg && s_axi_bready_i) begin
			bvalid_next = 1'b0;
		end
		if (wr_fire) begin
			aw_full_next = 1'b0;
			w_full_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = addr_ok(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
		end
		awready_next = !aw_full_next;
		wready_next = !w_full_next;
	end

	// ==========================================================
	// AXI4-Lite read channel: one read at a time, data registered.
	assign roff = s_axi_araddr_i - A_TBASE;
	assign ridx = roff[TIDX_W+3:4];
	assign rd_tmr = s_axi_araddr_i >= A_TBASE && s_axi_araddr_i < A_TEND;

	always_comb begin
		rd_mux = '0;
		case (s_axi_araddr_i)
			A_ARM: rd_mux = 32'(arm_reg);
			A_ENA: rd_mux = 32'(ena_reg);
			A_MODE: rd_mux = 32'(mode_reg);
			A_SENSE: rd_mux = 32'(sense_reg);
			A_CHAIN: rd_mux = 32'(chain_reg);
			A_REQ: rd_mux = 32'(req_reg);
			A_PEND: rd_mux = 32'(pend_reg);
			A_TPEND: rd_mux = 32'(tpend_reg);
			A_TIE: rd_mux = 32'(tie_reg);
			A_TCHAIN: rd_mux = 32'(tch_reg);
			A_TOUT: rd_mux = 32'(tout_reg);
			default: begin
				if (rd_tmr) begin
					case (roff[3:2])
						T_CTRL: begin
							rd_mux[CTL_START] = trun[ridx];
							rd_mux[CTL_PER] = per_reg[ridx];
							rd_mux[CTL_RES +: RES_W] = res_reg[ridx];
						end
						T_LOAD: rd_mux = 32'(tload[ridx]);
						T_COUNT: rd_mux = 32'(tcount[ridx]);
						default: rd_mux = '0;
					endcase
				end
			end
		endcase
	end

	always_comb begin
		arready_next = arready_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_axi_arvalid_i && arready_reg) begin
			arready_next = 1'b0;
			rvalid_next = 1'b1;
			rdata_next = rd_mux;
			rresp_next = addr_ok(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready_i) begin
			rvalid_next = 1'b0;
			arready_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			waddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b1;
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else begin
			aw_full_reg <= aw_full_next;
			w_full_reg <= w_full_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
		end
	end

	// ==========================================================
	// Control registers. Request, clear and command words act on the whole word.
	assign swreq = (wr_fire && waddr_reg == A_REQ) ? NIN'(wdata_reg) : '0;
	assign pclr = (wr_fire && waddr_reg == A_PEND) ? NIN'(wdata_reg) : '0;
	assign tclr = (wr_fire && waddr_reg == A_TPEND) ? NTMR'(wdata_reg) : '0;

	always_comb begin
		arm_next = (wr_fire && waddr_reg == A_ARM) ? NIN'(merge(32'(arm_reg), wdata_reg, wstrb_reg)) : arm_reg;
		ena_next = (wr_fire && waddr_reg == A_ENA) ? NIN'(merge(32'(ena_reg), wdata_reg, wstrb_reg)) : ena_reg;
		mode_next = (wr_fire && waddr_reg == A_MODE) ? NIN'(merge(32'(mode_reg), wdata_reg, wstrb_reg)) : mode_reg;
		sense_next = (wr_fire && waddr_reg == A_SENSE) ? NIN'(merge(32'(sense_reg), wdata_reg, wstrb_reg)) : sense_reg;
		chain_next = (wr_fire && waddr_reg == A_CHAIN) ? NIN'(merge(32'(chain_reg), wdata_reg, wstrb_reg)) : chain_reg;
		tie_next = (wr_fire && waddr_reg == A_TIE) ? NTMR'(merge(32'(tie_reg), wdata_reg, wstrb_reg)) : tie_reg;
		tch_next = (wr_fire && waddr_reg == A_TCHAIN) ? NTMR'(merge(32'(tch_reg), wdata_reg, wstrb_reg)) : tch_reg;
		tout_next = (wr_fire && waddr_reg == A_TOUT) ? NTMR'(merge(32'(tout_reg), wdata_reg, wstrb_reg)) : tout_reg;
		for (int t = 0; t < NTMR; t++) begin
			per_next[t] = per_reg[t];
			res_next[t] = res_reg[t];
			if (wr_fire && wr_tmr && widx == TIDX_W'(t) && woff[3:2] == T_CTRL) begin
				per_next[t] = wdata_reg[CTL_PER];
				res_next[t] = wdata_reg[CTL_RES +: RES_W];
			end
		end
	end

	// Reset leaves every input disarmed, disabled, unforwarded, falling-edge.
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			arm_reg <= '0;
			ena_reg <= '0;
			chain_reg <= '0;
			mode_reg <= '0;
			sense_reg <= '0;
			tie_reg <= '0;
			tch_reg <= '0;
			tout_reg <= '0;
			per_reg <= '0;
			for (int t = 0; t < NTMR; t++) begin
				res_reg[t] <= '0;
			end
		end else begin
			arm_reg <= arm_next;
			ena_reg <= ena_next;
			chain_reg <= chain_next;
			mode_reg <= mode_next;
			sense_reg <= sense_next;
			tie_reg <= tie_next;
			tch_reg <= tch_next;
			tout_reg <= tout_next;
			per_reg <= per_next;
			res_reg <= res_next;
		end
	end

	// ==========================================================
	// Input channels. Sampling every 5 ns catches any pulse held 1 us.
	// Sense 0 means falling edge or low level; sense 1 rising or high.
	always_comb begin
		for (int i = 0; i < NIN; i++) begin
			if (mode_reg[i]) begin
				trig[i] = sense_reg[i] ? sync_b_reg[i] : !sync_b_reg[i];
			end else if (sense_reg[i]) begin
				trig[i] = sync_b_reg[i] && !sync_c_reg[i];
			end else begin
				trig[i] = !sync_b_reg[i] && sync_c_reg[i];
			end
		end
		deliver = req_reg & ena_reg & arm_reg & ~pend_reg;
		req_next = arm_reg & ((req_reg & ~deliver) | trig | swreq);
		pend_next = (pend_reg & ~pclr) | deliver;
		ichain_next = chain_reg & trig;
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			sync_a_reg <= '0;
			sync_b_reg <= '0;
			sync_c_reg <= '0;
			req_reg <= '0;
			pend_reg <= '0;
			ichain_reg <= '0;
		end else begin
			sync_a_reg <= ext_irq_i;
			sync_b_reg <= sync_a_reg;
			sync_c_reg <= sync_b_reg;
			req_reg <= req_next;
			pend_reg <= pend_next;
			ichain_reg <= ichain_next;
		end
	end

	// ==========================================================
	// Tick generator: 1 us, 10 us, 100 us and 1 ms strobes.
	always_comb begin
		tick[0] = us_reg == US_W'(TICK_CYC - 1);
		us_next = tick[0] ? '0 : us_reg + US_W'(1);
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			us_reg <= '0;
		end else begin
			us_reg <= us_next;
		end
	end

	for (genvar k = 1; k < RES_STEPS; k++) begin : g_dec
		logic [3:0] dec_reg, dec_next;
		always_comb begin
			tick[k] = tick[k-1] && dec_reg == DECADE_LAST;
			dec_next = !tick[k-1] ? dec_reg : (tick[k] ? 4'h0 : dec_reg + 4'h1);
		end
		always_ff @(posedge sys_clk_i) begin
			if (sys_rst_i) begin
				dec_reg <= '0;
			end else begin
				dec_reg <= dec_next;
			end
		end
	end

	// ==========================================================
	// Timers and their expiry routing.
	for (genvar t = 0; t < NTMR; t++) begin : g_tmr
		logic sel;
		assign sel = wr_fire && wr_tmr && widx == TIDX_W'(t);
		eirqt_timer #(.W(CNT_W)) u_tmr (
			.sys_clk_i(sys_clk_i),
			.sys_rst_i(sys_rst_i),
			.tick_i(tick[res_reg[t]]),
			.start_i(sel && woff[3:2] == T_CTRL && wdata_reg[CTL_START]),
			.stop_i(sel && woff[3:2] == T_CTRL && wdata_reg[CTL_STOP]),
			.periodic_i(per_reg[t]),
			.load_we_i(sel && woff[3:2] == T_LOAD),
			.mod_we_i(sel && woff[3:2] == T_COUNT),
			.wdata_i(CNT_W'(wdata_reg)),
			.count_o(tcount[t]),
			.load_o(tload[t]),
			.running_o(trun[t]),
			.expire_o(texp[t])
		);
	end

	always_comb begin
		tpend_next = (tpend_reg & ~tclr) | texp;
		tirq_next = tpend_next & tie_reg;
		tchain_next = texp & tch_reg;
		tline_next = texp & tout_reg;
	end

	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			tpend_reg <= '0;
			tirq_reg <= '0;
			tchain_reg <= '0;
			tline_reg <= '0;
		end else begin
			tpend_reg <= tpend_next;
			tirq_reg <= tirq_next;
			tchain_reg <= tchain_next;
			tline_reg <= tline_next;
		end
	end

	assign s_axi_awready_o = awready_reg;
	assign s_axi_wready_o = wready_reg;
	assign s_axi_bresp_o = bresp_reg;
	assign s_axi_bvalid_o = bvalid_reg;
	assign s_axi_arready_o = arready_reg;
	assign s_axi_rdata_o = rdata_reg;
	assign s_axi_rresp_o = rresp_reg;
	assign s_axi_rvalid_o = rvalid_reg;
	assign in_irq_o = pend_reg;
	assign in_chain_o = ichain_reg;
	assign tmr_irq_o = tirq_reg;
	assign tmr_chain_o = tchain_reg;
	assign tmr_out_o = tline_reg;

	// ==========================================================
	// Checks.
	a_reset_idle: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> arm_reg == '0 && ena_reg == '0 && chain_reg == '0)
		else $error("inputs not idle after reset");
	a_default_fall: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> mode_reg == '0 && sense_reg == '0)
		else $error("inputs not on falling edge after reset");
	a_disarm_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		1'b1 |=> (req_reg & ~$past(arm_reg)) == '0)
		else $error("request held on a disarmed input");
	a_deliver_gate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		1'b1 |=> (pend_reg & ~$past(pend_reg) & ~$past(arm_reg & ena_reg & req_reg)) == '0)
		else $error("delivery without arm, enable and request");
	a_pend_sticky: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		1'b1 |=> ($past(pend_reg) & ~$past(pclr) & ~pend_reg) == '0)
		else $error("pending dropped without a clear");
	a_sw_request: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		swreq[0] && arm_reg[0] |=> req_reg[0] ##1 (pend_reg[0] || !ena_reg[0] || !arm_reg[0]))
		else $error("software request not taken");
	a_edge_fall: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		arm_reg[0] && !mode_reg[0] && !sense_reg[0] && $fell(sync_b_reg[0]) |=> req_reg[0])
		else $error("falling edge missed");
	a_chain_fwd: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		chain_reg[0] && trig[0] |=> in_chain_o[0])
		else $error("trigger not forwarded to chain");
	a_tmr_event: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
		texp[0] && tie_reg[0] |=> tpend_reg[0] && tmr_irq_o[0])
		else $error("timer expiry lost");
endmodule // eirqt_top

`default_nettype wire

//--- eirqt_line_model.sv
// Partner model: the external equipment that drives the interrupt input lines.
`default_nettype none

module eirqt_line_model (
	input wire logic clk_i,
	input wire logic [11:0] want_i,
	output logic [11:0] line_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Line driver
	int held = 1000;
	initial line_o = 12'hfff;
	// A level is kept 200 cycles (1 us) before the next change, so a bench request may lag.
	always @(posedge clk_i) begin
		if (want_i !== line_o && held >= 200) begin
			line_o <= want_i;
			held <= 0;
		end else begin
			held <= held + 1;
		end
	end
endmodule // eirqt_line_model

`default_nettype wire

//--- eirqt_top_bench.sv
// Self-checking bench for the interrupt inputs and interval timers.
`default_nettype none

module eirqt_top_bench import eirqt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals and instances
	logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
	logic awr, wr_r, bv, arr, rv;
	logic [1:0] br, rr, br_l;
	logic [7:0] aw = '0, ar = '0, ti, tc, to;
	logic [31:0] wd = '0, rd;
	logic [11:0] want = 12'hfff, ext, irq, chn;
	int n_errors = 0, comparisons = 0, cyc = 0, n;
	eirqt_top dut_u(.sys_clk_i(clk), .sys_rst_i(rst), .s_axi_awaddr_i(aw), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wr_r), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
		.s_axi_araddr_i(ar), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
		.s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .ext_irq_i(ext),
		.in_irq_o(irq), .in_chain_o(chn), .tmr_irq_o(ti), .tmr_chain_o(tc), .tmr_out_o(to));
	eirqt_line_model lm_u(.clk_i(clk), .want_i(want), .line_o(ext));
	initial forever #2.5 clk = ~clk;
	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Ready is sampled at the falling edge so the release after the rising edge never races.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		aw <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		bre <= 1;
		do begin
			@(negedge clk);
			ta = awr & awv;
			tw = wr_r & wv;
			tb = bv;
			br_l = br;
			@(posedge clk);
			if (ta) awv <= 0;
			if (tw) wv <= 0;
		end while (!tb);
		bre <= 0;
	endtask
	task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic tk, tr;
		@(posedge clk);
		ar <= a;
		arv <= 1;
		rre <= 1;
		do begin
			@(negedge clk);
			tk = arr & arv;
			tr = rv;
			d = rd;
			r = rr;
			@(posedge clk);
			if (tk) arv <= 0;
		end while (!tr);
		rre <= 0;
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rdw(a, d, r);
		chk(nm, e, d);
	endtask
	// Waits for an input interrupt or a timer output bit, giving up after 1000 cycles.
	// Returns at a falling edge, so the caller compares settled outputs and catches one-cycle pulses.
	task automatic wt(input int b, input logic tmr, output int k);
		k = 0;
		do begin
			@(negedge clk);
			k++;
		end while (!(tmr ? to[b] : irq[b]) && k < 1000);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		rchk("arm", A_ARM, '0);
		rchk("enable", A_ENA, '0);
		rchk("mode", A_MODE, '0);
		rchk("sense", A_SENSE, '0);
		rdw(8'h4c, d, r);
		chk("hole", RESP_SLVERR, r);
		wr(8'h3c, 32'hfff);
		chk("wresp", RESP_SLVERR, br_l);
		rchk("noeffect", A_ARM, '0);
		$display("t_reset done");
	endtask
	task automatic t_edge;
		wr(A_ARM, 32'hfff);
		wr(A_ENA, 32'hfff);
		chk("wok", RESP_OKAY, br_l);
		want[0] <= 0;
		wt(0, 0, n);
		chk("fall", 12'h001, irq);
		wr(A_REQ, 32'h1);
		repeat (300) @(negedge clk);
		chk("held", 12'h001, irq);
		wr(A_PEND, 32'h1);
		repeat (3) @(negedge clk);
		chk("redo", 12'h001, irq);
		wr(A_PEND, 32'h1);
		// The line rises only now, so a wrongly taken rising edge cannot hide behind the software request.
		want[0] <= 1;
		repeat (8) @(negedge clk);
		chk("rise", '0, irq);
		$display("t_edge done");
	endtask
	task automatic t_hold;
		wr(A_ENA, '0);
		wr(A_REQ, 32'h2);
		repeat (8) @(negedge clk);
		chk("off", '0, irq);
		wr(A_ENA, 32'hfff);
		wt(1, 0, n);
		chk("on", 12'h002, irq);
		wr(A_PEND, 32'h2);
		wr(A_ENA, '0);
		wr(A_REQ, 32'h2);
		wr(A_ARM, 32'hffd);
		rchk("disarm", A_REQ, '0);
		wr(A_ARM, 32'hfff);
		wr(A_ENA, 32'hfff);
		repeat (8) @(negedge clk);
		chk("stale", '0, irq);
		$display("t_hold done");
	endtask
	task automatic t_level;
		wr(A_CHAIN, 32'h4);
		wr(A_SENSE, 32'h4);
		wr(A_MODE, 32'h4);
		wt(2, 0, n);
		chk("high", 12'h004, irq);
		chk("chain", 12'h004, chn);
		wr(A_SENSE, '0);
		wr(A_ARM, 32'hffb);
		wr(A_PEND, 32'h4);
		wr(A_ARM, 32'hfff);
		repeat (8) @(negedge clk);
		chk("idle", '0, irq);
		want[2] <= 0;
		wt(2, 0, n);
		chk("low", 12'h004, irq);
		$display("t_level done");
	endtask
	task automatic t_timer;
		wr(A_TIE, 32'h2);
		wr(A_TCHAIN, 32'h2);
		wr(A_TOUT, 32'h2);
		wr(8'h54, 32'h3);
		wr(8'h50, 32'h5);
		rchk("run", 8'h50, 32'h5);
		wt(1, 1, n);
		chk("tchain", 8'h02, tc);
		@(negedge clk);
		wt(1, 1, n);
		chk("period", 600, n + 1);
		chk("tirq", 8'h02, ti);
		wr(8'h50, 32'h2);
		rchk("stop", 8'h50, 32'h0);
		wr(8'h54, 32'h2);
		wr(8'h50, 32'h1);
		wt(1, 1, n);
		@(negedge clk);
		wt(1, 1, n);
		chk("once", 1000, n);
		rchk("count", 8'h58, '0);
		wr(A_TPEND, 32'h2);
		repeat (3) @(negedge clk);
		chk("tclr", '0, ti);
		// A 10 us resolution with load 1 in periodic mode expires once every 2000 cycles.
		wr(8'h54, 32'h1);
		wr(8'h50, 32'h15);
		rchk("res", 8'h50, 32'h15);
		wt(1, 1, n);
		if (n == 1000) wt(1, 1, n);
		if (n == 1000) wt(1, 1, n);
		@(negedge clk);
		wt(1, 1, n);
		wt(1, 1, n);
		chk("decade", 999, n);
		$display("t_timer done");
	endtask
	// ==========================================================
	// Sequence, timeout and verdict
	task automatic close_out;
		$display("compared %0d, mismatched %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			close_out;
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		t_reset;
		t_edge;
		t_hold;
		t_level;
		t_timer;
		close_out;
	end
endmodule // eirqt_top_bench

`default_nettype wire
